// File: dv/cdao_dac_model.sv
// Receiving D/A converter model for one slot serial stream
`timescale 1ns/1ps
module cdao_dac_model #(
  parameter int BITS      = 24,
  parameter bit LSB_FIRST = 1'b0
) (
  // Clock
  input  wire logic       i_clk,
  // Serial stream
  input  wire logic       i_bclk,
  input  wire logic       i_lr,
  input  wire logic       i_data,
  // Last words per channel
  output logic [BITS-1:0] o_left,
  output logic [BITS-1:0] o_right
);
  logic            bclk_q = 1'b0;
  logic            lr_q   = 1'b0;
  logic [BITS-1:0] shift_r;
  // ----------------
  // Capture
  // ----------------
  // Oversampled at the system clock, as the port registers its clocks there
  always @(posedge i_clk) begin
    bclk_q <= i_bclk;
    lr_q   <= i_lr;
    if (i_bclk && !bclk_q) begin
      if (LSB_FIRST) begin
        shift_r <= {i_data, shift_r[BITS-1:1]};
      end else begin
        shift_r <= {shift_r[BITS-2:0], i_data};
      end
    end
    // Channel clock high carries the left word
    if (i_lr != lr_q) begin
      if (lr_q) begin
        o_left <= shift_r;
      end else begin
        o_right <= shift_r;
      end
    end
  end
endmodule

// File: dv/testbench.sv
// Self-checking bench of the audio output port
`timescale 1ns/1ps
module testbench;
  import cdao_pkg::*;
  typedef struct packed {
    logic [8:0]  mon;
    logic [7:0]  jit;
    logic [10:0] exp;
  } cdao_row_t;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         rst_n = 1'b1;
  logic         fmt = 1'b0;
  logic         xsel = 1'b0;
  logic         xtal = 1'b0;
  logic         pitch = 1'b0;
  logic         mute = 1'b0;
  cdao_sample_t smp = '0;
  logic         vld = 1'b0;
  cdao_mon_t    mon = '0;
  logic [7:0]   jit = 8'h00;
  logic         hsel = 1'b0;
  logic [7:0]   haddr = 8'h00;
  logic [1:0]   htrans = 2'b00;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hready;
  logic [15:0]  pins;
  logic         ws;
  logic         lrc;
  logic [2:0]   cko;
  logic         irq;
  logic [4:0]   clks;
  logic [23:0]  l48;
  logic [23:0]  r48;
  logic [31:0]  l64;
  logic [31:0]  r64;
  logic [31:0]  rd;
  logic         ce = 1'b1;
  logic         pitch_on = 1'b1;
  logic [2:0]   hsize = 3'b010;
  logic         hresp;
  logic [20:0]  snap;
  int           tog [5];
  int           fails = 0;
  int           checks_done = 0;
  // Monitor inputs and jitter beside the expected pins 11..1, bit-7 pin masked
  cdao_row_t    rows [5] = '{'{9'h000, 8'h00, 11'h110}, '{9'h1FF, 8'h1C, 11'h6BF},
    '{9'h0A5, 8'h1D, 11'h385}, '{9'h15A, 8'hE3, 11'h42A}, '{9'h000, 8'hE4, 11'h110}};
  assign clks = {ws, lrc, cko};
  always #5 clk = ~clk;
  // Crystal clock makes one transition per cycle, pitch clock too while pitch_on is high
  always @(posedge clk) begin
    xtal  <= ~xtal;
    pitch <= pitch_on ? ~pitch : pitch;
  end
  cdao_top #(.FRAME_CLK_CYC(10)) cdao_top_inst (
    .I_CLK(clk), .I_CLK_EN(ce), .I_SYS_RST(rst), .I_SYSTEM_RESET_N(rst_n),
    .I_OUTPUT_FORMAT_SELECT(fmt), .I_CRYSTAL_FREQ_SELECT(xsel), .I_CRYSTAL_INPUT(xtal),
    .I_PITCH_CLOCK(pitch), .I_MUTE(mute), .I_SAMPLE(smp), .I_SAMPLE_VALID(vld), .I_MON(mon),
    .I_BUFFER_JITTER(jit), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .O_AUDIO_PINS(pins), .O_SLOT48_WORD_STROBE(ws), .O_SLOT48_CHANNEL_CLOCK(lrc),
    .O_TWO_THIRDS_CLOCK_OUT(cko[2]), .O_QUARTER_CLOCK_OUT(cko[1]),
    .O_PITCH_TRACKING_CLOCK_OUT(cko[0]), .O_IRQ(irq));
  cdao_dac_model dac48_inst (.i_clk(clk), .i_bclk(pins[14]),
    .i_lr(lrc), .i_data(pins[15]), .o_left(l48), .o_right(r48));
  cdao_dac_model #(.BITS(32), .LSB_FIRST(1'b1)) dac64_inst (.i_clk(clk), .i_bclk(pins[12]),
    .i_lr(pins[11]), .i_data(pins[13]), .o_left(l64), .o_right(r64));
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Single word transfer; the watchdog bounds the ready waits
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic count(input int n);
    logic [4:0] p;
    tog = '{default: 0};
    @(negedge clk);
    p = clks;
    repeat (n) begin
      @(negedge clk);
      for (int k = 0; k < 5; k++) if (clks[k] !== p[k]) tog[k]++;
      p = clks;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test;
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    wait_n(11);
    chk("pins in reset", pins, 32'h0);
    chk("ready in reset", hready, 32'h1);
    chk("okay response", hresp, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    ahb(8'h00, 1'b0, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    ahb(8'h20, 1'b0, 32'h0);
    chk("unmapped read", rd, 32'h0);
    foreach (rows[i]) begin
      @(posedge clk);
      mon <= rows[i].mon;
      jit <= rows[i].jit;
      wait_n(4);
      chk("monitors", pins[10:0] & 11'h7BF, rows[i].exp & 11'h7BF);
    end
    ahb(8'h08, 1'b0, 32'h0);
    chk("event status", rd, 32'h7);
    ahb(8'h0C, 1'b1, 32'h1);
    wait_n(3);
    chk("irq enabled", irq, 32'h1);
    ahb(8'h0C, 1'b1, 32'h0);
    wait_n(3);
    chk("irq masked", irq, 32'h0);
    ahb(8'h10, 1'b1, 32'h7);
    ahb(8'h08, 1'b0, 32'h0);
    chk("status cleared", rd, 32'h0);
    // Serial pins and clocks must hold still while the enable is low
    @(posedge clk);
    ce <= 1'b0;
    wait_n(1);
    snap = {pins, clks};
    wait_n(100);
    chk("frozen by enable", {pins, clks}, snap);
    @(posedge clk);
    ce <= 1'b1;
    smp <= 32'hA5C31234;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    wait_n(6912);
    chk("slot48 left", l48, 32'hFFA5C3);
    chk("slot48 right", r48, 32'h001234);
    chk("slot64 left", l64, 32'hFFFFA5C3);
    chk("slot64 right", r64, 32'h00001234);
    count(4608);
    chk("word strobe", tog[4], 32'd8);
    chk("channel clock", tog[3], 32'd4);
    chk("two thirds", tog[2], 32'd3072);
    chk("quarter", tog[1], 32'd1152);
    chk("pitch direct", tog[0], 32'd4608);
    @(posedge clk);
    xsel <= 1'b1;
    wait_n(8);
    count(4608);
    chk("two thirds", tog[2], 32'd3072);
    chk("quarter", tog[1], 32'd1152);
    chk("pitch halved", tog[0], 32'd2304);
    // Halted pitch clock: fixed dividers keep running, tracking clock stops
    @(posedge clk);
    pitch_on <= 1'b0;
    wait_n(8);
    count(4608);
    chk("two thirds no pitch", tog[2], 32'd3072);
    chk("quarter no pitch", tog[1], 32'd1152);
    chk("pitch halted", tog[0], 32'd0);
    @(posedge clk);
    pitch_on <= 1'b1;
    fmt <= 1'b1;
    @(posedge lrc);
    wait_n(4);
    chk("left word", pins, 32'hA5C3);
    @(negedge lrc);
    wait_n(4);
    chk("right word", pins, 32'h1234);
    @(posedge clk);
    mute <= 1'b1;
    wait_n(4);
    chk("muted", pins, 32'h0);
    @(posedge clk);
    mute <= 1'b0;
    ahb(8'h00, 1'b1, 32'h1);
    wait_n(4);
    chk("soft muted", pins, 32'h0);
    ahb(8'h00, 1'b1, 32'h0);
    ahb(8'h04, 1'b0, 32'h0);
    chk("status", rd, 32'h1);
    jit <= 8'h1D;
    ahb(8'h0C, 1'b1, 32'h1);
    wait_n(3);
    chk("irq overflow", irq, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    wait_n(2);
    chk("irq in reset", irq, 32'h0);
    chk("pins in reset", pins, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    ahb(8'h0C, 1'b0, 32'h0);
    chk("enable reset", rd, 32'h0);
    end_of_test;
  end
endmodule

// File: src/cdao_evdiv.sv
// Divider stepping on input transition events, toggling on masked phases
`timescale 1ns/1ps
module cdao_evdiv #(
  parameter int              CYCLE = 6,
  parameter logic [CYCLE-1:0] MASK = 6'b011011
) (
  // Clock and control
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Event in, divided clock out
  input  wire logic i_ev,
  output logic      o_clk
);
  localparam int CW = (CYCLE > 1) ? $clog2(CYCLE) : 1;

  logic [CW-1:0] cnt_r;
  logic          out_r;

  wire           last_w = cnt_r == CW'(CYCLE - 1);
  wire [CW-1:0]  cnt_nxt = last_w ? '0 : cnt_r + 1'b1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else if (i_ce && i_ev) begin
      cnt_r <= cnt_nxt;
      out_r <= out_r ^ MASK[cnt_r];
    end
  end

  assign o_clk = out_r;
endmodule

// File: src/cdao_map.svh
// Offsets, field positions, reset values and timing counts of the audio output port
// What this block does
// - Format select high gives parallel word pins, low gives serial streams and monitors.
// - Word clock of the 48-bit slot runs at twice the sampling rate.
// - Channel clock of the 48-bit slot runs at the sampling rate.
// - Parallel format puts audio bits 16 down to 1 on their own pins.
// - Serial format: 48-bit slot data on bit-16 pin, its bit clock on bit-15.
// - Serial format: 64-bit slot data, bit clock, channel clock on pins 14, 13, 12.
// - Serial format: window status, raw sync, inverted PLL clock, lock, frame clock on 11..7.
// - Serial format: data error status on bit-6 pin, buffer overflow on bit-5 pin.
// - Serial format: monitor signals 3 down to 0 on bit-4 to bit-1 pins.
// - Two-thirds crystal clock output, independent of variable pitch.
// - Quarter crystal clock output, independent of variable pitch.
// - 16.9344MHz clock output that follows variable pitch.
// - Audio output is muted while the mute input is high.
// - Block held in reset while the active-low system reset is low.
// - 64-bit slot samples go least significant bit first, two's complement.
// - 48-bit slot samples go most significant bit first, two's complement.
// - Window status monitor is high while the sync protection window is released.
// - Overflow indication asserts when buffer jitter exceeds plus or minus 28 frames.
`ifndef CDAO_MAP_SVH
`define CDAO_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CDAO_OFS_CTRL      8'h00
`define CDAO_OFS_STATUS    8'h04
`define CDAO_OFS_IRQ_STAT  8'h08
`define CDAO_OFS_IRQ_EN    8'h0C
`define CDAO_OFS_IRQ_CLR   8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CDAO_CTRL_SOFT_MUTE 0
`define CDAO_ST_FORMAT      0
`define CDAO_ST_LOCKED      1
`define CDAO_ST_OVERFLOW    2
`define CDAO_ST_MUTED       3
`define CDAO_EV_OVERFLOW    0
`define CDAO_EV_LOCK_LOST   1
`define CDAO_EV_DATA_ERR    2
`define CDAO_CTRL_RST       1'h0
`define CDAO_IRQ_EN_RST     3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CDAO_CLK_PERIOD_NS  10
`define CDAO_FRAME_CLK_NS   136000
`define CDAO_FRAME_CLK_CYC  ((`CDAO_FRAME_CLK_NS / 2) / `CDAO_CLK_PERIOD_NS)
`define CDAO_JITTER_FRAMES  28
`define CDAO_S48_HALF_CYC   24
`define CDAO_S64_HALF_CYC   18

`endif

// File: src/cdao_pkg.sv
// Types shared by the audio output port
package cdao_pkg;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } cdao_sample_t;

  typedef struct packed {
    logic       sync_window_status;
    logic       raw_frame_sync_pulse_n;
    logic       pll_clock;
    logic       frame_sync_locked;
    logic       data_error_status;
    logic [3:0] monitor_sig;
  } cdao_mon_t;

  typedef enum logic [1:0] {
    CDAO_BUS_IDLE  = 2'b01,
    CDAO_BUS_WRITE = 2'b10
  } cdao_bus_t;

endpackage

// File: src/cdao_slot_ser.sv
// Slot serializer: bit clock, channel clock, word clock and two's complement data
`timescale 1ns/1ps
module cdao_slot_ser
  import cdao_pkg::*;
#(
  parameter int SLOT_BITS = 48,
  parameter int HALF_CYC  = 24,
  parameter bit MSB_FIRST = 1'b1
) (
  // Clock and control
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_ce,
  // Sample in
  input  wire cdao_sample_t  i_sample,
  input  wire logic          i_mute,
  // Serial out
  output logic               o_bclk,
  output logic               o_lrclk,
  output logic               o_wclk,
  output logic               o_data
);
  localparam int W  = SLOT_BITS / 2;
  localparam int CW = $clog2(SLOT_BITS);
  localparam int HW = $clog2(HALF_CYC);

  logic [HW-1:0] half_r;
  logic [CW-1:0] bit_r;
  logic          bclk_r;
  logic          data_r;
  cdao_sample_t  snap_r;

  wire          half_end = half_r == HW'(HALF_CYC - 1);
  wire          fall_w   = half_end && bclk_r;
  wire          last_bit = bit_r == CW'(SLOT_BITS - 1);
  wire [CW-1:0] bit_nxt  = last_bit ? '0 : bit_r + 1'b1;
  wire          right_w  = bit_nxt >= CW'(W);
  wire [CW-1:0] pos_w    = right_w ? bit_nxt - CW'(W) : bit_nxt;
  // Frame start takes the fresh sample so the left word is never stale
  wire cdao_sample_t cur_w = (bit_nxt == '0) ? i_sample : snap_r;
  wire signed [15:0] chan_w = i_mute ? 16'sh0000 : (right_w ? cur_w.right : cur_w.left);
  wire [31:0]   word_w   = {{16{chan_w[15]}}, chan_w};
  // Sign extension fills the slot padding
  wire [4:0]    idx_w    = MSB_FIRST ? 5'(W - 1) - 5'(pos_w) : 5'(pos_w);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      half_r <= '0;
      bit_r  <= CW'(SLOT_BITS - 1);
      bclk_r <= 1'b0;
      data_r <= 1'b0;
      snap_r <= '0;
    end else if (i_ce) begin
      half_r <= half_end ? '0 : half_r + 1'b1;
      if (half_end) begin
        bclk_r <= ~bclk_r;
      end
      if (fall_w) begin
        bit_r  <= bit_nxt;
        data_r <= word_w[idx_w];
        if (bit_nxt == '0) begin
          snap_r <= i_sample;
        end
      end
    end
  end

  assign o_bclk  = bclk_r;
  assign o_data  = data_r;
  assign o_lrclk = bit_r < CW'(W);
  assign o_wclk  = (bit_r < CW'(W / 2)) ||
                   ((bit_r >= CW'(W)) && (bit_r < CW'(W + W / 2)));
endmodule

// File: src/cdao_top.sv
// Audio output port: pin mux, slot serializers, clock outputs, AHB-Lite registers
`timescale 1ns/1ps
`include "cdao_map.svh"
module cdao_top #(
  parameter int FRAME_CLK_CYC = `CDAO_FRAME_CLK_CYC,
  parameter int S48_HALF_CYC  = `CDAO_S48_HALF_CYC,
  parameter int S64_HALF_CYC  = `CDAO_S64_HALF_CYC
) (
  // Clock, enable, resets
  input  wire logic                 I_CLK,
  input  wire logic                 I_CLK_EN,
  input  wire logic                 I_SYS_RST,
  input  wire logic                 I_SYSTEM_RESET_N,
  // Straps and playback inputs
  input  wire logic                 I_OUTPUT_FORMAT_SELECT,
  input  wire logic                 I_CRYSTAL_FREQ_SELECT,
  input  wire logic                 I_CRYSTAL_INPUT,
  input  wire logic                 I_PITCH_CLOCK,
  input  wire logic                 I_MUTE,
  input  wire cdao_pkg::cdao_sample_t I_SAMPLE,
  input  wire logic                 I_SAMPLE_VALID,
  input  wire cdao_pkg::cdao_mon_t  I_MON,
  input  wire logic signed [7:0]    I_BUFFER_JITTER,
  // AHB-Lite slave
  input  wire logic                 HSEL,
  input  wire logic [7:0]           HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic [31:0]               HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  // Audio pins, index 15 is the bit-16 pin
  output logic [15:0]               O_AUDIO_PINS,
  output logic                      O_SLOT48_WORD_STROBE,
  output logic                      O_SLOT48_CHANNEL_CLOCK,
  // Clock outputs and interrupt
  output logic                      O_TWO_THIRDS_CLOCK_OUT,
  output logic                      O_QUARTER_CLOCK_OUT,
  output logic                      O_PITCH_TRACKING_CLOCK_OUT,
  output logic                      O_IRQ
);
  import cdao_pkg::*;

  // ----------------------------------------
  // Reset and input stage
  // ----------------------------------------
  wire rst = I_SYS_RST || !I_SYSTEM_RESET_N;
  wire ce  = I_CLK_EN;

  logic         fmt_r;
  logic         xtal_q_r;
  logic         pitch_q_r;
  logic         c16_r;
  cdao_sample_t sample_r;
  cdao_mon_t    mon_r;
  logic         ovf_n_r;
  logic         lock_q_r;
  logic         err_q_r;

  wire [7:0] jit_abs   = I_BUFFER_JITTER[7] ? 8'(-I_BUFFER_JITTER) : I_BUFFER_JITTER;
  wire       jit_over  = jit_abs > 8'(`CDAO_JITTER_FRAMES);

  always_ff @(posedge I_CLK) begin
    if (rst) begin
      fmt_r     <= 1'b0;
      xtal_q_r  <= 1'b0;
      pitch_q_r <= 1'b0;
      sample_r  <= '0;
      mon_r     <= '0;
      ovf_n_r   <= 1'b1;
      lock_q_r  <= 1'b0;
      err_q_r   <= 1'b0;
    end else if (ce) begin
      fmt_r     <= I_OUTPUT_FORMAT_SELECT;
      xtal_q_r  <= I_CRYSTAL_INPUT;
      pitch_q_r <= I_PITCH_CLOCK;
      mon_r     <= I_MON;
      ovf_n_r   <= !jit_over;
      lock_q_r  <= mon_r.frame_sync_locked;
      err_q_r   <= mon_r.data_error_status;
      if (I_SAMPLE_VALID) begin
        sample_r <= I_SAMPLE;
      end
    end
  end

  // ----------------------------------------
  // Registers over AHB-Lite
  // ----------------------------------------
  logic        soft_mute_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_en_r;
  logic [7:0]  wr_addr_r;
  cdao_bus_t   bus_st_r;
  logic [31:0] hrdata_r;
  logic        irq_r;

  wire        mute_act = I_MUTE || soft_mute_r;
  wire        acc_w    = HSEL && HREADY && HTRANS[1] && ce;
  wire        wr_w     = acc_w && HWRITE;
  wire        rd_w     = acc_w && !HWRITE;
  wire        do_wr    = (bus_st_r == CDAO_BUS_WRITE) && ce;
  wire        wr_ctrl  = do_wr && (wr_addr_r == `CDAO_OFS_CTRL);
  wire        wr_en    = do_wr && (wr_addr_r == `CDAO_OFS_IRQ_EN);
  wire        wr_clr   = do_wr && (wr_addr_r == `CDAO_OFS_IRQ_CLR);
  wire [3:0]  status_w = {mute_act, !ovf_n_r, mon_r.frame_sync_locked, fmt_r};
  wire [2:0]  ev_w     = {mon_r.data_error_status && !err_q_r,
                          !mon_r.frame_sync_locked && lock_q_r,
                          jit_over && ovf_n_r};
  // Hardware set beats a same-cycle software clear
  wire [2:0]  clr_w    = wr_clr ? HWDATA[2:0] : 3'h0;
  wire [2:0]  stat_nxt = (irq_stat_r & ~clr_w) | ev_w;
  wire [31:0] rd_mux   = (HADDR == `CDAO_OFS_CTRL)     ? {31'h0, soft_mute_r} :
                         (HADDR == `CDAO_OFS_STATUS)   ? {28'h0, status_w} :
                         (HADDR == `CDAO_OFS_IRQ_STAT) ? {29'h0, irq_stat_r} :
                         (HADDR == `CDAO_OFS_IRQ_EN)   ? {29'h0, irq_en_r} : 32'h0;

  always_ff @(posedge I_CLK) begin
    if (rst) begin
      bus_st_r  <= CDAO_BUS_IDLE;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0;
    end else if (ce) begin
      bus_st_r  <= wr_w ? CDAO_BUS_WRITE : CDAO_BUS_IDLE;
      wr_addr_r <= wr_w ? HADDR : wr_addr_r;
      if (rd_w) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (rst) begin
      soft_mute_r <= `CDAO_CTRL_RST;
      irq_en_r    <= `CDAO_IRQ_EN_RST;
      irq_stat_r  <= 3'h0;
      irq_r       <= 1'b0;
    end else if (ce) begin
      soft_mute_r <= wr_ctrl ? HWDATA[`CDAO_CTRL_SOFT_MUTE] : soft_mute_r;
      irq_en_r    <= wr_en ? HWDATA[2:0] : irq_en_r;
      irq_stat_r  <= stat_nxt;
      irq_r       <= |(stat_nxt & (wr_en ? HWDATA[2:0] : irq_en_r));
    end
  end

  assign HRDATA    = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign O_IRQ     = irq_r;

  // ----------------------------------------
  // Slot serializers
  // ----------------------------------------
  logic s48_bclk;
  logic s48_lr;
  logic s48_wclk;
  logic s48_data;
  logic s64_bclk;
  logic s64_lr;
  logic s64_data;

  cdao_slot_ser #(.SLOT_BITS(48), .HALF_CYC(S48_HALF_CYC), .MSB_FIRST(1'b1)) u_s48 (
    .i_clk    (I_CLK),
    .i_rst    (rst),
    .i_ce     (ce),
    .i_sample (sample_r),
    .i_mute   (mute_act),
    .o_bclk   (s48_bclk),
    .o_lrclk  (s48_lr),
    .o_wclk   (s48_wclk),
    .o_data   (s48_data)
  );

  cdao_slot_ser #(.SLOT_BITS(64), .HALF_CYC(S64_HALF_CYC), .MSB_FIRST(1'b0)) u_s64 (
    .i_clk    (I_CLK),
    .i_rst    (rst),
    .i_ce     (ce),
    .i_sample (sample_r),
    .i_mute   (mute_act),
    .o_bclk   (s64_bclk),
    .o_lrclk  (s64_lr),
    .o_wclk   (),
    .o_data   (s64_data)
  );

  // ----------------------------------------
  // Frame clock and clock outputs
  // ----------------------------------------
  localparam int FW = $clog2(FRAME_CLK_CYC);
  logic [FW-1:0] fcnt_r;
  logic          fclk_r;
  logic          two3_w;
  logic          quart_w;
  logic          two3_r;
  logic          quart_r;

  wire fcnt_end = fcnt_r == FW'(FRAME_CLK_CYC - 1);
  wire xtal_ev  = I_CRYSTAL_INPUT ^ xtal_q_r;
  wire pitch_ev = I_PITCH_CLOCK ^ pitch_q_r;
  // A 33.8688MHz crystal is halved so the output stays at 16.9344MHz
  wire c16_tgl  = pitch_ev && (!I_CRYSTAL_FREQ_SELECT || I_PITCH_CLOCK);

  always_ff @(posedge I_CLK) begin
    if (rst) begin
      fcnt_r  <= '0;
      fclk_r  <= 1'b0;
      c16_r   <= 1'b0;
      two3_r  <= 1'b0;
      quart_r <= 1'b0;
    end else if (ce) begin
      fcnt_r  <= fcnt_end ? '0 : fcnt_r + 1'b1;
      fclk_r  <= fclk_r ^ fcnt_end;
      c16_r   <= c16_r ^ c16_tgl;
      two3_r  <= two3_w;
      quart_r <= quart_w;
    end
  end

  // Fixed crystal dividers, blind to the pitch clock
  cdao_evdiv #(.CYCLE(6), .MASK(6'b011011)) u_two3 (
    .i_clk (I_CLK),
    .i_rst (rst),
    .i_ce  (ce),
    .i_ev  (xtal_ev),
    .o_clk (two3_w)
  );

  cdao_evdiv #(.CYCLE(4), .MASK(4'b1000)) u_quart (
    .i_clk (I_CLK),
    .i_rst (rst),
    .i_ce  (ce),
    .i_ev  (xtal_ev),
    .o_clk (quart_w)
  );

  assign O_TWO_THIRDS_CLOCK_OUT     = two3_r;
  assign O_QUARTER_CLOCK_OUT        = quart_r;
  assign O_PITCH_TRACKING_CLOCK_OUT = c16_r;

  // ----------------------------------------
  // Pin multiplexer
  // ----------------------------------------
  logic [15:0] pins_r;
  logic        wclk_r;
  logic        lrclk_r;

  wire [15:0] par_w = mute_act ? 16'h0000 : (s48_lr ? sample_r.left : sample_r.right);
  wire [15:0] ser_w = {s48_data, s48_bclk,
                       s64_data, s64_bclk, s64_lr,
                       mon_r.sync_window_status, mon_r.raw_frame_sync_pulse_n,
                       !mon_r.pll_clock, mon_r.frame_sync_locked, fclk_r,
                       mon_r.data_error_status, ovf_n_r,
                       mon_r.monitor_sig};

  always_ff @(posedge I_CLK) begin
    if (rst) begin
      pins_r  <= 16'h0000;
      wclk_r  <= 1'b0;
      lrclk_r <= 1'b0;
    end else if (ce) begin
      pins_r  <= fmt_r ? par_w : ser_w;
      wclk_r  <= s48_wclk;
      lrclk_r <= s48_lr;
    end
  end

  assign O_AUDIO_PINS           = pins_r;
  assign O_SLOT48_WORD_STROBE   = wclk_r;
  assign O_SLOT48_CHANNEL_CLOCK = lrclk_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_par_word;
    @(posedge I_CLK) disable iff (rst)
      (ce && fmt_r && !mute_act) |=> O_AUDIO_PINS == $past(s48_lr ? sample_r.left : sample_r.right);
  endproperty
  a_par_word: assert property (p_par_word) else $error("Parallel word wrong");

  property p_mute;
    @(posedge I_CLK) disable iff (rst) (ce && fmt_r && I_MUTE) |=> O_AUDIO_PINS == 16'h0000;
  endproperty
  a_mute: assert property (p_mute) else $error("Mute not applied");

  property p_s48_pins;
    @(posedge I_CLK) disable iff (rst)
      (ce && !fmt_r) |=> (O_AUDIO_PINS[15] == $past(s48_data)) && (O_AUDIO_PINS[14] == $past(s48_bclk));
  endproperty
  a_s48_pins: assert property (p_s48_pins) else $error("48-bit slot pins wrong");

  property p_s64_pins;
    @(posedge I_CLK) disable iff (rst)
      (ce && !fmt_r) |=> O_AUDIO_PINS[13:11] == $past({s64_data, s64_bclk, s64_lr});
  endproperty
  a_s64_pins: assert property (p_s64_pins) else $error("64-bit slot pins wrong");

  property p_mon_pins;
    @(posedge I_CLK) disable iff (rst)
      (!rst && ce && !fmt_r) |=> (O_AUDIO_PINS[8] == !$past(mon_r.pll_clock))
                      && (O_AUDIO_PINS[10] == $past(mon_r.sync_window_status));
  endproperty
  a_mon_pins: assert property (p_mon_pins) else $error("Monitor pins wrong");

  property p_ovf;
    @(posedge I_CLK) disable iff (rst) (!rst && ce && jit_over) ##1 (ce && !fmt_r) |=> !O_AUDIO_PINS[4];
  endproperty
  a_ovf: assert property (p_ovf) else $error("Overflow not shown");

  property p_mnt;
    @(posedge I_CLK) disable iff (rst) (ce && !fmt_r) |=> O_AUDIO_PINS[3:0] == $past(mon_r.monitor_sig);
  endproperty
  a_mnt: assert property (p_mnt) else $error("General monitors wrong");

  property p_wclk;
    @(posedge I_CLK) disable iff (rst) $changed(O_SLOT48_CHANNEL_CLOCK) |-> O_SLOT48_WORD_STROBE;
  endproperty
  a_wclk: assert property (p_wclk) else $error("Word clock not aligned");

  property p_err;
    @(posedge I_CLK) disable iff (rst)
      (ce && !fmt_r) |=> O_AUDIO_PINS[5] == $past(mon_r.data_error_status);
  endproperty
  a_err: assert property (p_err) else $error("Error status pin wrong");

  property p_reset;
    @(posedge I_CLK) rst |=> (O_AUDIO_PINS == 16'h0000) && !O_IRQ && !O_SLOT48_CHANNEL_CLOCK;
  endproperty
  a_reset: assert property (p_reset) else $error("Outputs not cleared by reset");

  // Sampled reset in the antecedent keeps the release edge out of the check
  property p_ovf_flag;
    @(posedge I_CLK) disable iff (rst)
      (!rst && ce && jit_over && ovf_n_r) |=> irq_stat_r[`CDAO_EV_OVERFLOW];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow event lost");

  property p_c16;
    @(posedge I_CLK) disable iff (rst)
      (!rst && ce && !I_CRYSTAL_FREQ_SELECT && pitch_ev) |=> $changed(O_PITCH_TRACKING_CLOCK_OUT);
  endproperty
  a_c16: assert property (p_c16) else $error("Tracking clock missed a pitch edge");

  c_par: cover property (@(posedge I_CLK) disable iff (rst) fmt_r ##1 !fmt_r);
  c_irq: cover property (@(posedge I_CLK) disable iff (rst) $rose(O_IRQ));
  c_lr:  cover property (@(posedge I_CLK) disable iff (rst) $rose(O_SLOT48_CHANNEL_CLOCK));
endmodule
